/* File: verilog/rsf_defs.svh */
// offsets, field positions and reset values of the reset-cause block
`ifndef RSF_DEFS_SVH
`define RSF_DEFS_SVH

// register addresses on the internal 16-bit bus
`define RSF_ADDR_CAUSE 16'hFFAC
`define RSF_ADDR_LVCTRL 16'hFFBE
`define RSF_ADDR_LVSEL 16'hFFBF
`define RSF_ADDR_INTR_BASE 16'hFFE0

// reset-cause flag positions
`define RSF_BIT_WDOG 4
`define RSF_BIT_CLKMON 1
`define RSF_BIT_LOWVOLT 0
`define RSF_CAUSE_MASK 8'h13

// interrupt bank layout, by index from the base address
`define RSF_NUM_INTR 14
`define RSF_IDX_MK0L 4
`define RSF_IDX_INTR_MASK_GROUP1_HIGH 7
`define RSF_IDX_INTR_PRIORITY_GROUP0_LOW 8
`define RSF_IDX_EGP 12

// reset values
`define RSF_CAUSE_RST 8'h00
`define RSF_LV_RST 8'h00
`define RSF_IF_RST 8'h00
`define RSF_MK_RST 8'hFF
`define RSF_INTR_MASK_GROUP1_HIGH_RST 8'hDF
`define RSF_PR_RST 8'hFF
`define RSF_EG_RST 8'h00
`define RSF_RDATA_RST 8'h00

`endif

/* File: verilog/rsf_pkg.sv */
// types and shared decode of the reset-cause block
package rsf_pkg;
`include "rsf_defs.svh"

	typedef logic [7:0] byte_t;

	// reset image of one interrupt bank register
	function automatic byte_t intr_rst_val(input int idx);
		byte_t v;
		v = `RSF_EG_RST;
		if (idx == `RSF_IDX_INTR_MASK_GROUP1_HIGH) begin
			v = `RSF_INTR_MASK_GROUP1_HIGH_RST;
		end else if (idx < `RSF_IDX_MK0L) begin
			v = `RSF_IF_RST;
		end else if (idx < `RSF_IDX_INTR_PRIORITY_GROUP0_LOW) begin
			v = `RSF_MK_RST;
		end else if (idx < `RSF_IDX_EGP) begin
			v = `RSF_PR_RST;
		end
		return v;
	endfunction

endpackage

/* File: verilog/intr_bus_if.sv */
// carrier between the reset-cause top and the interrupt register bank
`timescale 1ns/1ps
interface intr_bus_if #(
	parameter int N = 14
);
	logic [N-1:0] wr_sel;
	logic [7:0] wdata;
	logic sys_reset;
	logic [7:0] q [N];

	modport top (output wr_sel, output wdata, output sys_reset, input q);
	modport bank (input wr_sel, input wdata, input sys_reset, output q);
endinterface

/* File: verilog/intr_reg_bank.sv */
// interrupt request, mask, priority and edge enable registers
`timescale 1ns/1ps
module intr_reg_bank #(
	parameter int N = 14
) (
	input wire logic clk,
	input wire logic arst_n,
	intr_bus_if.bank bus
);
	import rsf_pkg::*;

	genvar i;
	for (i = 0; i < N; i++) begin : g_reg
		// any reset source restores the documented image
		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				bus.q[i] <= intr_rst_val(i);
			end else if (bus.sys_reset) begin
				bus.q[i] <= intr_rst_val(i);
			end else if (bus.wr_sel[i]) begin
				bus.q[i] <= bus.wdata;
			end
		end

		property p_intr_reset;
			@(posedge clk) disable iff (!arst_n)
			bus.sys_reset |=> (bus.q[i] == intr_rst_val(i)) [*1];
		endproperty
		a_intr_reset: assert property (p_intr_reset)
			else $error("interrupt register missed its reset image");
	end
endmodule

/* File: verilog/reset_source_flags.sv */
// reset-cause record, low-voltage register reset and interrupt bank reset
//
// How it works
// - cause byte: bit4 watchdog, bit1 clock, bit0 voltage
// - external, power-on or read clears cause byte
// - cause byte is read-only, whole-byte read
// - watchdog reset sets its flag, others held
// - clock monitor reset sets its flag, others held
// - low-voltage reset sets its flag, others held
// - voltage registers cleared except on a voltage reset alone
// - interrupt registers take their fixed reset image
// - flag one means that source requested reset
`timescale 1ns/1ps
`include "rsf_defs.svh"
module reset_source_flags #(
	parameter int NUM_INTR_REGS = `RSF_NUM_INTR
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ext_reset,
	input wire logic power_on_clear,
	input wire logic watchdog_unit,
	input wire logic clock_stop_monitor,
	input wire logic low_voltage_detector,
	input wire logic [15:0] addr,
	input wire logic rd_en,
	input wire logic wr_en,
	input wire rsf_pkg::byte_t wdata,
	output rsf_pkg::byte_t rdata,
	output rsf_pkg::byte_t reset_cause_flags,
	output rsf_pkg::byte_t lowvolt_detect_ctrl,
	output rsf_pkg::byte_t lowvolt_level_select,
	output logic [8*NUM_INTR_REGS-1:0] intr_regs
);
	import rsf_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// reset source classes

	// external and power-on resets wipe all but the read data register, the record included
	wire wipe = ext_reset | power_on_clear;
	wire internal_any = watchdog_unit | clock_stop_monitor
		| low_voltage_detector;
	wire sys_reset = wipe | internal_any;
	// a voltage reset must not reset the voltage detector's own setup
	wire lv_clear = wipe | watchdog_unit | clock_stop_monitor;

	////////////////////////////////////////////////////////////////////////
	// address decode

	function automatic logic hit(input logic [15:0] a,
		input logic [15:0] base);
		return a == base;
	endfunction

	wire cause_rd = rd_en & hit(addr, `RSF_ADDR_CAUSE);
	wire lvc_hit = hit(addr, `RSF_ADDR_LVCTRL);
	wire lvs_hit = hit(addr, `RSF_ADDR_LVSEL);
	// writes lose to a reset arriving in the same cycle
	wire wr_ok = wr_en & ~sys_reset;
	wire lvc_wr = wr_ok & lvc_hit;
	wire lvs_wr = wr_ok & lvs_hit;

	wire [15:0] intr_off = addr - `RSF_ADDR_INTR_BASE;
	wire intr_hit = (addr >= `RSF_ADDR_INTR_BASE)
		& (intr_off < 16'(NUM_INTR_REGS));

	intr_bus_if #(.N(NUM_INTR_REGS)) ibus ();

	assign ibus.wdata = wdata;
	assign ibus.sys_reset = sys_reset;

	genvar i;
	for (i = 0; i < NUM_INTR_REGS; i++) begin : g_intr
		assign ibus.wr_sel[i] = wr_ok
			& hit(addr, `RSF_ADDR_INTR_BASE + 16'(i));
		assign intr_regs[8*i +: 8] = ibus.q[i];
	end

	intr_reg_bank #(.N(NUM_INTR_REGS)) u_bank (
		.clk(clk),
		.arst_n(arst_n),
		.bus(ibus)
	);

	////////////////////////////////////////////////////////////////////////
	// reset-cause record

	byte_t cause_r;
	byte_t cause_nxt;
	byte_t cause_set;

	// each source sets its own bit, so coincident sources all show
	assign cause_set = (8'(watchdog_unit) << `RSF_BIT_WDOG)
		| (8'(clock_stop_monitor) << `RSF_BIT_CLKMON)
		| (8'(low_voltage_detector) << `RSF_BIT_LOWVOLT);

	// a set in the clearing read's cycle survives; a wipe beats all
	assign cause_nxt = wipe ? `RSF_CAUSE_RST
		: (((cause_rd ? `RSF_CAUSE_RST : cause_r) | cause_set)
		& `RSF_CAUSE_MASK);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cause_r <= `RSF_CAUSE_RST;
		end else begin
			cause_r <= cause_nxt;
		end
	end

	assign reset_cause_flags = cause_r;

	////////////////////////////////////////////////////////////////////////
	// low-voltage detector setup registers

	byte_t lvc_r;
	byte_t lvs_r;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lvc_r <= `RSF_LV_RST;
		end else if (lv_clear) begin
			lvc_r <= `RSF_LV_RST;
		end else if (lvc_wr) begin
			lvc_r <= wdata;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lvs_r <= `RSF_LV_RST;
		end else if (lv_clear) begin
			lvs_r <= `RSF_LV_RST;
		end else if (lvs_wr) begin
			lvs_r <= wdata;
		end
	end

	assign lowvolt_detect_ctrl = lvc_r;
	assign lowvolt_level_select = lvs_r;

	////////////////////////////////////////////////////////////////////////
	// read port: data registered one cycle after the strobe

	byte_t rdata_r;
	byte_t rd_sel;

	// the cause byte has no write path at all; unmapped reads give zero
	assign rd_sel = cause_rd ? cause_r
		: lvc_hit ? lvc_r
		: lvs_hit ? lvs_r
		: intr_hit ? ibus.q[intr_off[3:0]]
		: `RSF_RDATA_RST;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_r <= `RSF_RDATA_RST;
		end else if (rd_en) begin
			rdata_r <= rd_sel;
		end
	end

	assign rdata = rdata_r;

	////////////////////////////////////////////////////////////////////////
	// checks

	sequence s_wdog_evt;
		watchdog_unit && !wipe;
	endsequence

	sequence s_quiet2;
		(!wipe && !cause_rd) [*2];
	endsequence

	property p_reserved_zero;
		@(posedge clk) disable iff (!arst_n)
		(cause_r & ~`RSF_CAUSE_MASK) == 8'h00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved cause bit set");

	property p_read_clears;
		@(posedge clk) disable iff (!arst_n)
		cause_rd && !internal_any |=> cause_r == 8'h00;
	endproperty
	a_read_clears: assert property (p_read_clears)
		else $error("cause byte not cleared by read");

	property p_wipe_clears;
		@(posedge clk) disable iff (!arst_n)
		wipe |=> cause_r == 8'h00 ##1 (cause_r == 8'h00 || $past(sys_reset));
	endproperty
	a_wipe_clears: assert property (p_wipe_clears)
		else $error("cause byte not cleared by wipe");

	property p_read_data;
		@(posedge clk) disable iff (!arst_n)
		cause_rd |=> rdata == $past(cause_r);
	endproperty
	a_read_data: assert property (p_read_data)
		else $error("read data differs from cause byte");

	property p_wdog_set;
		@(posedge clk) disable iff (!arst_n)
		s_wdog_evt and (!cause_rd && !clock_stop_monitor
			&& !low_voltage_detector)
		|=> cause_r == ($past(cause_r) | 8'h10);
	endproperty
	a_wdog_set: assert property (p_wdog_set)
		else $error("watchdog flag wrong");

	property p_clkmon_set;
		@(posedge clk) disable iff (!arst_n)
		clock_stop_monitor && !wipe && !cause_rd && !watchdog_unit
		&& !low_voltage_detector |=> cause_r == ($past(cause_r) | 8'h02);
	endproperty
	a_clkmon_set: assert property (p_clkmon_set)
		else $error("clock monitor flag wrong");

	property p_lowvolt_set;
		@(posedge clk) disable iff (!arst_n)
		low_voltage_detector && !wipe && !cause_rd && !watchdog_unit
		&& !clock_stop_monitor |=> cause_r == ($past(cause_r) | 8'h01);
	endproperty
	a_lowvolt_set: assert property (p_lowvolt_set)
		else $error("low-voltage flag wrong");

	property p_lv_clear;
		@(posedge clk) disable iff (!arst_n)
		lv_clear |=> lvc_r == 8'h00 && lvs_r == 8'h00;
	endproperty
	a_lv_clear: assert property (p_lv_clear)
		else $error("voltage setup not cleared");

	property p_lv_hold;
		@(posedge clk) disable iff (!arst_n)
		low_voltage_detector && !lv_clear |=> $stable(lvc_r) && $stable(lvs_r);
	endproperty
	a_lv_hold: assert property (p_lv_hold)
		else $error("voltage setup lost on voltage reset");

	property p_flag_persists;
		@(posedge clk) disable iff (!arst_n)
		s_wdog_evt ##1 s_quiet2 |-> cause_r[`RSF_BIT_WDOG];
	endproperty
	a_flag_persists: assert property (p_flag_persists)
		else $error("watchdog flag dropped before clear");

	property p_all_set;
		@(posedge clk) disable iff (!arst_n)
		watchdog_unit && clock_stop_monitor && low_voltage_detector && !wipe
		|=> cause_r == 8'h13;
	endproperty
	a_all_set: assert property (p_all_set)
		else $error("coincident sources not all recorded");

endmodule

/* File: testbench/tb_reset_source_flags.sv */
// self-checking bench for the reset-cause block
`timescale 1ns/1ps
`include "rsf_defs.svh"
module tb_reset_source_flags;
	import rsf_pkg::*;
	localparam logic [15:0] BASE = `RSF_ADDR_INTR_BASE;
	localparam int NB = 8 * `RSF_NUM_INTR;
	logic clk;
	logic arst_n;
	logic rd_en;
	logic wr_en;
	logic pend = 1'b0;
	logic [4:0] src; // poc, ext, lowvolt, clkmon, wdog
	logic [15:0] addr;
	byte_t wdata;
	byte_t rdata;
	logic [8*`RSF_NUM_INTR-1:0] intr_o;
	byte_t exp_q[$];
	// state image noted with each read: cause, ctrl, select, bank
	logic [NB+23:0] st_q[$];
	logic [NB+23:0] st_e;
	byte_t cause_o;
	byte_t lvc_o;
	byte_t lvs_o;
	byte_t cause_m;
	byte_t lvc_m;
	byte_t lvs_m;
	byte_t bank_m[`RSF_NUM_INTR];
	int failures;
	int comparisons;

	reset_source_flags i_dut (.clk(clk), .arst_n(arst_n),
		.ext_reset(src[3]), .power_on_clear(src[4]),
		.watchdog_unit(src[0]), .clock_stop_monitor(src[1]),
		.low_voltage_detector(src[2]), .addr(addr), .rd_en(rd_en),
		.wr_en(wr_en), .wdata(wdata), .rdata(rdata),
		.reset_cause_flags(cause_o), .lowvolt_detect_ctrl(lvc_o),
		.lowvolt_level_select(lvs_o), .intr_regs(intr_o));

	////////////////////////////////////////////////////////////////////////
	task automatic compare_byte(input string what, input byte_t e,
		input byte_t g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic compare_bank(input logic [NB-1:0] e,
		input logic [NB-1:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("BAD intr_regs expected %h seen %h", e, g);
		end
	endtask

	task automatic stop_test();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	function automatic byte_t img(input int i);
		if (i == `RSF_IDX_INTR_MASK_GROUP1_HIGH) return 8'hDF; // upper mask
		if (i >= `RSF_IDX_MK0L && i < `RSF_IDX_EGP) return 8'hFF;
		return 8'h00; // request and edge bytes
	endfunction

	function automatic logic in_bank(input logic [15:0] a);
		return a >= BASE && a < BASE + `RSF_NUM_INTR;
	endfunction

	function automatic logic [NB-1:0] bank_vec();
		logic [NB-1:0] v;
		for (int i = 0; i < `RSF_NUM_INTR; i++) v[8*i +: 8] = bank_m[i];
		return v;
	endfunction

	function automatic byte_t mread(input logic [15:0] a);
		if (a == `RSF_ADDR_CAUSE) return cause_m;
		if (a == `RSF_ADDR_LVCTRL) return lvc_m;
		if (a == `RSF_ADDR_LVSEL) return lvs_m;
		if (in_bank(a)) return bank_m[a - BASE];
		return 8'h00;
	endfunction

	task automatic model_reset();
		cause_m = 8'h00;
		lvc_m = 8'h00;
		lvs_m = 8'h00;
		for (int i = 0; i < `RSF_NUM_INTR; i++) bank_m[i] = img(i);
	endtask

	// one bus cycle, whole bytes only with reset sources
	task automatic cyc(input logic rd, input logic wr,
		input logic [15:0] a, input byte_t d, input logic [4:0] s);
		@(posedge clk);
		rd_en <= rd;
		wr_en <= wr;
		addr <= a;
		wdata <= d;
		src <= s;
		if (rd) exp_q.push_back(mread(a));
		if (rd && a == `RSF_ADDR_CAUSE) cause_m = 8'h00;
		if (wr && s == 5'd0) begin
			// cause byte takes no write
			if (a == `RSF_ADDR_LVCTRL) lvc_m = d;
			if (a == `RSF_ADDR_LVSEL) lvs_m = d;
			if (in_bank(a)) bank_m[a - BASE] = d;
		end
		if (s[4:3] != 2'd0) cause_m = 8'h00; // wipe wins
		else cause_m = cause_m | {3'd0, s[0], 2'd0, s[1], s[2]};
		if (s[4:3] != 2'd0 || s[1:0] != 2'd0) begin
			lvc_m = 8'h00; // low-voltage source alone keeps
			lvs_m = 8'h00;
		end
		if (s != 5'd0) for (int i = 0; i < `RSF_NUM_INTR; i++) bank_m[i] = img(i);
		if (rd) st_q.push_back({cause_m, lvc_m, lvs_m, bank_vec()});
	endtask

	task automatic rd(input logic [15:0] a, input logic [4:0] s);
		cyc(1'b1, 1'b0, a, 8'h00, s);
	endtask

	task automatic check_all();
		rd(`RSF_ADDR_CAUSE, 5'd0);
		rd(`RSF_ADDR_LVCTRL, 5'd0);
		rd(`RSF_ADDR_LVSEL, 5'd0);
		for (int i = 0; i < `RSF_NUM_INTR; i++) rd(BASE + 16'(i), 5'd0);
		cyc(1'b0, 1'b0, 16'h0000, 8'h00, 5'd0);
	endtask

	////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		if (pend) begin
			if (exp_q.size() == 0 || st_q.size() == 0) begin
				failures++;
				$display("BAD note queue expected 1 seen 0");
			end else begin
				compare_byte("rdata", exp_q.pop_front(), rdata);
				// state outputs settle in the same edge that takes the read
				st_e = st_q.pop_front();
				compare_byte("reset_cause_flags", st_e[NB+16 +: 8],
					cause_o);
				compare_byte("lowvolt_detect_ctrl", st_e[NB+8 +: 8],
					lvc_o);
				compare_byte("lowvolt_level_select", st_e[NB +: 8],
					lvs_o);
				compare_bank(st_e[NB-1:0], intr_o);
			end
		end
		pend <= rd_en;
	end

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial begin
		#(100000 * 8);
		failures++;
		stop_test();
	end

	initial begin
		logic [15:0] a;
		logic [4:0] s;
		logic op;
		arst_n = 1'b0;
		{rd_en, wr_en, src, addr, wdata} <= '0;
		failures = 0;
		comparisons = 0;
		void'($urandom(84524));
		model_reset();
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		check_all();
		cyc(1'b0, 1'b1, `RSF_ADDR_CAUSE, 8'hFF, 5'd0);
		rd(`RSF_ADDR_CAUSE, 5'b0_0001); // set beats clear
		rd(`RSF_ADDR_CAUSE, 5'd0);
		rd(16'h1234, 5'd0); // unmapped read
		cyc(1'b0, 1'b0, 16'h0000, 8'h00, 5'b0_0010);
		cyc(1'b0, 1'b0, 16'h0000, 8'h00, 5'b0_0100);
		rd(`RSF_ADDR_CAUSE, 5'b0_0001);
		rd(`RSF_ADDR_CAUSE, 5'b0_1000); // external wipe
		rd(`RSF_ADDR_CAUSE, 5'b1_0000); // power-on wipe
		for (int n = 0; n < 400; n++) begin
			case ($urandom_range(0, 4))
				0: a = `RSF_ADDR_CAUSE;
				1: a = `RSF_ADDR_LVCTRL;
				2: a = `RSF_ADDR_LVSEL;
				3: a = 16'h1234;
				default: a = BASE + 16'($urandom_range(0, 13));
			endcase
			s = 5'd0;
			if ($urandom_range(0, 3) == 0) s = {$urandom_range(0, 7) == 0,
				$urandom_range(0, 7) == 0, 3'($urandom_range(0, 7))};
			op = 1'($urandom_range(0, 1));
			cyc(op, !op, a, 8'($urandom), s);
		end
		check_all();
		@(posedge clk);
		arst_n <= 1'b0;
		model_reset();
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		check_all();
		for (int i = 0; i < 8 && exp_q.size() != 0; i++) @(posedge clk);
		if (exp_q.size() != 0 || st_q.size() != 0) failures++;
		stop_test();
	end
endmodule
